// >>> eeprom_write_ctrl.v
// Data EEPROM controller: read mode, latched write mode, programming.
// Assumes a CPU register port with read data one cycle after strobe.
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_ctrl_defs.vh"
module eeprom_write_ctrl #(
  parameter PROG_CYCLES = `PROG_CYCLES,
  parameter [7:0] EE_BASE = `EE_BASE_ADDR
)(
  input wire clk_i,
  input wire reset_n_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  output reg rdata_oe_o,
  input wire wait_req_i,
  input wire halt_req_i,
  input wire protect_i,
  input wire ext_access_i,
  input wire unprotect_req_i,
  output reg wait_ack_o,
  output reg halted_o,
  output reg busy_o,
  output reg irq_o
);
  localparam ST_IDLE = 2'd0;
  localparam ST_PROG = 2'd1;
  localparam ST_WAIT = 2'd2;
  localparam ST_HALT = 2'd3;
  localparam [31:0] PROG_LAST = PROG_CYCLES - 1;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg lat_r;
  reg pgm_r;
  reg [1:0] row_r;
  reg [4:0] col_r;
  reg [31:0] tmr_r;
  reg [3:0] isr_r;
  reg [3:0] imr_r;
  reg [1:0] wait_s_r;
  reg [1:0] halt_s_r;
  reg [1:0] prot_s_r;
  reg [1:0] ext_s_r;
  reg [1:0] unp_s_r;
  reg unp_d_r;
  reg erase_r;
  reg rd_ee_r;
  reg rd_reg_r;
  reg [7:0] reg_rdata_r;

  wire wait_s = wait_s_r[1];
  wire halt_s = halt_s_r[1];
  wire prot_s = prot_s_r[1];
  wire ext_s = ext_s_r[1];
  wire unp_s = unp_s_r[1];
  wire unp_rise = unp_s & ~unp_d_r;
  wire erase_go = unp_rise & prot_s;
  // Offset into the EEPROM window; row and column follow it, not the raw address.
  wire [7:0] ee_off = addr_i - EE_BASE;

  // The bound is formed one bit wider, so a window ending at the top of the map cannot wrap to zero.
  function is_ee;
    input [7:0] a;
    begin
      is_ee = ({1'b0, a} >= {1'b0, EE_BASE}) && ({1'b0, a} < ({1'b0, EE_BASE} + 9'd128));
    end
  endfunction

  function [7:0] ecs_word;
    input lat;
    input pgm;
    begin
      ecs_word = 8'h00;
      ecs_word[`ECS_LAT_BIT] = lat;
      ecs_word[`ECS_PGM_BIT] = pgm;
    end
  endfunction

  wire ee_wr = wr_i & is_ee(addr_i);
  wire ee_rd = rd_i & is_ee(addr_i);
  wire ecs_wr = wr_i & (addr_i == `ECS_OFFSET);
  wire blocked = prot_s & ext_s;
  wire latch_wr = ee_wr & lat_r & ~pgm_r & ~blocked & (state_r == ST_IDLE);
  wire bad_wr = ee_wr & ~lat_r;
  wire bad_rd = ee_rd & lat_r;
  wire lat_set = ecs_wr & wdata_i[`ECS_LAT_BIT];
  // A start taken outside idle would leave the bit set with no cycle to clear it.
  wire start_ok = (state_r == ST_IDLE) & ~halt_s;
  wire pgm_set = ecs_wr & wdata_i[`ECS_PGM_BIT] & lat_r & ~pgm_r & ~blocked & start_ok;
  wire tmr_done = (state_r == ST_PROG) && (tmr_r == PROG_LAST);
  wire prog_end = tmr_done & ~halt_s;
  wire abort = (state_r == ST_PROG) & (halt_s | (ecs_wr & ~wdata_i[`ECS_PGM_BIT]));
  wire lat_fall_sw = ecs_wr & ~wdata_i[`ECS_LAT_BIT] & ~pgm_r & lat_r;
  reg [3:0] ev;

  wire [7:0] arr_rdata;
  wire [7:0] lat_rdata;
  wire lat_valid;
  wire arr_wr = (state_r == ST_PROG) & ~halt_s & lat_valid;
  wire lat_clear = prog_end | lat_fall_sw | abort;

  // ==========================================================
  // Event vector
  always @*
  begin
    ev = 4'h0;
    ev[`IRQ_DONE_BIT] = prog_end;
    ev[`IRQ_ABORT_BIT] = abort;
    ev[`IRQ_ERR_BIT] = bad_wr | bad_rd;
    ev[`IRQ_ERASE_BIT] = erase_go;
  end

  // ==========================================================
  // Input synchronisers
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wait_s_r <= 2'b00;
      halt_s_r <= 2'b00;
      prot_s_r <= 2'b00;
      ext_s_r <= 2'b00;
      unp_s_r <= 2'b00;
      unp_d_r <= 1'b0;
    end
    else
    begin
      wait_s_r <= {wait_s_r[0], wait_req_i};
      halt_s_r <= {halt_s_r[0], halt_req_i};
      prot_s_r <= {prot_s_r[0], protect_i};
      ext_s_r <= {ext_s_r[0], ext_access_i};
      unp_s_r <= {unp_s_r[0], unprotect_req_i};
      unp_d_r <= unp_s;
    end
  end

  // ==========================================================
  // Power and programming state machine
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        if (halt_s)
          state_nxt = ST_HALT;
        else if (pgm_set)
          state_nxt = ST_PROG;
        else if (wait_s)
          state_nxt = ST_WAIT;
      end
      ST_PROG:
      begin
        if (halt_s)
          state_nxt = ST_HALT;
        else if (abort)
          state_nxt = ST_IDLE;
        else if (tmr_done)
          state_nxt = wait_s ? ST_WAIT : ST_IDLE;
      end
      ST_WAIT:
      begin
        if (halt_s)
          state_nxt = ST_HALT;
        else if (!wait_s)
          state_nxt = ST_IDLE;
      end
      ST_HALT:
      begin
        if (!halt_s)
          state_nxt = ST_IDLE;
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_r <= ST_IDLE;
      tmr_r <= 32'd0;
      col_r <= 5'd0;
    end
    else
    begin
      state_r <= state_nxt;
      // One byte column per clock; the timer covers the whole row.
      if (state_r == ST_PROG)
      begin
        tmr_r <= tmr_r + 32'd1;
        col_r <= col_r + 5'd1;
      end
      else
      begin
        tmr_r <= 32'd0;
        col_r <= 5'd0;
      end
    end
  end

  // ==========================================================
  // Control/status register
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      lat_r <= 1'b0;
      pgm_r <= 1'b0;
      row_r <= 2'd0;
    end
    else
    begin
      if (prog_end | abort)
      begin
        pgm_r <= 1'b0;
        lat_r <= 1'b0;
      end
      else
      begin
        if (pgm_set)
          pgm_r <= 1'b1;
        if (lat_set)
          lat_r <= 1'b1;
        else if (lat_fall_sw)
          lat_r <= 1'b0;
      end
      if (latch_wr)
        row_r <= ee_off[6:5];
    end
  end

  // ==========================================================
  // Interrupt status and mask
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      isr_r <= 4'h0;
      imr_r <= 4'h0;
      irq_o <= 1'b0;
    end
    else
    begin
      // A new event wins over a write-one clear in the same cycle.
      isr_r <= (isr_r & ~((wr_i && addr_i == `ISR_OFFSET) ? wdata_i[3:0] : 4'h0)) | ev;
      if (wr_i && addr_i == `IMR_OFFSET)
        imr_r <= wdata_i[3:0];
      irq_o <= |(isr_r & imr_r);
    end
  end

  // ==========================================================
  // Erase on protection removal
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      erase_r <= 1'b0;
    else
      erase_r <= erase_go;
  end

  // ==========================================================
  // Read path
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rd_ee_r <= 1'b0;
      rd_reg_r <= 1'b0;
      reg_rdata_r <= 8'h00;
    end
    else
    begin
      // Latched data never reaches the bus.
      rd_ee_r <= ee_rd & ~lat_r & ~blocked;
      rd_reg_r <= rd_i & ~is_ee(addr_i);
      case (addr_i)
        `ECS_OFFSET: reg_rdata_r <= ecs_word(lat_r, pgm_r);
        `ISR_OFFSET: reg_rdata_r <= {4'h0, isr_r};
        `IMR_OFFSET: reg_rdata_r <= {4'h0, imr_r};
        default: reg_rdata_r <= 8'h00;
      endcase
    end
  end

  always @*
  begin
    rdata_o = 8'h00;
    rdata_oe_o = 1'b0;
    if (rd_ee_r)
    begin
      rdata_o = arr_rdata;
      rdata_oe_o = 1'b1;
    end
    else if (rd_reg_r)
    begin
      rdata_o = reg_rdata_r;
      rdata_oe_o = 1'b1;
    end
  end

  // ==========================================================
  // Status outputs
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wait_ack_o <= 1'b0;
      halted_o <= 1'b0;
      busy_o <= 1'b0;
    end
    else
    begin
      wait_ack_o <= (state_nxt == ST_WAIT);
      halted_o <= (state_nxt == ST_HALT);
      busy_o <= (state_nxt == ST_PROG);
    end
  end

  // ==========================================================
  // Sub-blocks
  row_latches #(.CW(`COL_W), .N(`ROW_BYTES)) u_lat (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .clear_i(lat_clear),
    .wr_i(latch_wr),
    .wr_col_i(ee_off[4:0]),
    .wr_data_i(wdata_i),
    .rd_col_i(col_r),
    .rd_data_o(lat_rdata),
    .rd_valid_o(lat_valid)
  );

  eeprom_array #(.AW(`EE_ADDR_W), .DEPTH(`EE_DEPTH)) u_arr (
    .clk_i(clk_i),
    .rd_addr_i(ee_off[6:0]),
    .rd_data_o(arr_rdata),
    .wr_en_i(arr_wr),
    .wr_addr_i({row_r, col_r}),
    .wr_data_i(lat_rdata),
    .erase_i(erase_r)
  );
endmodule
`default_nettype wire

// >>> eeprom_ctrl_defs.vh
// Constants for the data EEPROM write controller.
// Assumes a single 125 MHz clock and an 8-bit register port.
`ifndef EEPROM_CTRL_DEFS_VH
`define EEPROM_CTRL_DEFS_VH
// ==========================================================
// Register map
`define EE_BASE_ADDR 8'h80
`define ECS_OFFSET 8'h30
`define ISR_OFFSET 8'h31
`define IMR_OFFSET 8'h32
`define ECS_RESET 8'h00
`define ECS_LAT_BIT 1
`define ECS_PGM_BIT 0
`define IRQ_DONE_BIT 0
`define IRQ_ABORT_BIT 1
`define IRQ_ERR_BIT 2
`define IRQ_ERASE_BIT 3
// ==========================================================
// Memory geometry and timing
`define EE_DEPTH 128
`define EE_ADDR_W 7
`define ROW_BYTES 32
`define COL_W 5
`define PROG_TIME_US 3000
`define CLK_MHZ 125
`define PROG_CYCLES (`PROG_TIME_US * `CLK_MHZ)
`endif

// >>> eeprom_array.v
// Data EEPROM cell array with registered read data.
// Assumes the controller owns every write and erase strobe.
`timescale 1ns/10ps
`default_nettype none
module eeprom_array #(
  parameter AW = 7,
  parameter DEPTH = 128
)(
  input wire clk_i,
  input wire [AW-1:0] rd_addr_i,
  output reg [7:0] rd_data_o,
  input wire wr_en_i,
  input wire [AW-1:0] wr_addr_i,
  input wire [7:0] wr_data_i,
  input wire erase_i
);
  reg [7:0] mem [0:DEPTH-1];
  integer k;
  // ==========================================================
  // Storage
  // Cells have no reset; contents are non-volatile by intent.
  always @(posedge clk_i)
  begin
    if (erase_i)
    begin
      for (k = 0; k < DEPTH; k = k + 1)
        mem[k] <= 8'hff;
    end
    else if (wr_en_i)
      mem[wr_addr_i] <= wr_data_i;
    rd_data_o <= mem[rd_addr_i];
  end
endmodule
`default_nettype wire

// >>> row_latches.v
// Thirty-two byte write latches with per-byte valid flags.
// Assumes one write or one clear per cycle from the controller.
`timescale 1ns/10ps
`default_nettype none
module row_latches #(
  parameter CW = 5,
  parameter N = 32
)(
  input wire clk_i,
  input wire reset_n_i,
  input wire clear_i,
  input wire wr_i,
  input wire [CW-1:0] wr_col_i,
  input wire [7:0] wr_data_i,
  input wire [CW-1:0] rd_col_i,
  output wire [7:0] rd_data_o,
  output wire rd_valid_o
);
  reg [7:0] data_r [0:N-1];
  reg [N-1:0] valid_r;
  integer k;
  // ==========================================================
  // Latches
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      valid_r <= {N{1'b0}};
      for (k = 0; k < N; k = k + 1)
        data_r[k] <= 8'hff;
    end
    else if (clear_i)
    begin
      valid_r <= {N{1'b0}};
      for (k = 0; k < N; k = k + 1)
        data_r[k] <= 8'hff;
    end
    else if (wr_i)
    begin
      // Repeated writes over-program: bytes combine by AND.
      data_r[wr_col_i] <= data_r[wr_col_i] & wr_data_i;
      valid_r[wr_col_i] <= 1'b1;
    end
  end
  assign rd_data_o = data_r[rd_col_i];
  assign rd_valid_o = valid_r[rd_col_i];
endmodule
`default_nettype wire

// >>> eeprom_ctrl_monitor.sv
// ==========================================
// Port checker for the data EEPROM controller.
// Assumes EE_BASE of 8'h80 and 2-flop synced level inputs.
`timescale 1ns/10ps
`default_nettype none
module eeprom_ctrl_monitor #(
  parameter PROG_CYCLES = 40
)(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic rdata_oe_o,
  input wire logic wait_req_i,
  input wire logic halt_req_i,
  input wire logic protect_i,
  input wire logic ext_access_i,
  input wire logic wait_ack_o,
  input wire logic halted_o,
  input wire logic busy_o
);
  int busy_cnt;
  logic halt_seen;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // A halt cuts a cycle short, so the length check must know one was seen.
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      busy_cnt <= 0;
      halt_seen <= 1'b0;
    end
    else
    begin
      busy_cnt <= busy_o ? busy_cnt + 1 : 0;
      halt_seen <= halt_req_i | (halt_seen & ~$rose(busy_o));
    end
  end
  sequence wait_held;
    (wait_req_i && !busy_o) [*4];
  endsequence
  sequence halt_held;
    halt_req_i [*4];
  endsequence
  ctrl_read_zero_a: assert property (rd_i && addr_i == 8'h30 |=> rdata_oe_o && rdata_o[7:2] == 6'h00)
    else $error("control read wrong");
  latch_read_float_a: assert property (rd_i && addr_i[7] && busy_o |=> !rdata_oe_o)
    else $error("bus driven in write mode");
  answer_slot_a: assert property (rdata_oe_o |-> $past(rd_i))
    else $error("data without read");
  prog_length_a: assert property ($fell(busy_o) |-> halt_seen || busy_cnt inside {[PROG_CYCLES-1:PROG_CYCLES+1]})
    else $error("cycle length wrong");
  prog_bound_a: assert property (busy_cnt <= PROG_CYCLES + 2)
    else $error("cycle never ends");
  wait_busy_a: assert property (wait_ack_o |-> !busy_o)
    else $error("wait while busy");
  wait_entry_a: assert property (wait_held |-> ##[0:2] wait_ack_o)
    else $error("wait not entered");
  halt_stop_a: assert property (halt_held |-> ##[0:2] (halted_o && !busy_o))
    else $error("halt not taken");
  start_cause_a: assert property ($rose(busy_o) |-> $past(wr_i) && $past(wdata_i[0]) || $past(wr_i, 2))
    else $error("start without write");
  protect_read_a: assert property ((protect_i && ext_access_i) [*4] ##0 rd_i && addr_i[7] |=> !rdata_oe_o)
    else $error("protected read driven");
endmodule
bind eeprom_write_ctrl eeprom_ctrl_monitor #(.PROG_CYCLES(PROG_CYCLES)) u_mon (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .rdata_oe_o(rdata_oe_o), .wait_req_i(wait_req_i),
  .halt_req_i(halt_req_i), .protect_i(protect_i), .ext_access_i(ext_access_i),
  .wait_ack_o(wait_ack_o), .halted_o(halted_o), .busy_o(busy_o));
`default_nettype wire

// >>> cpu_bus_model.sv
// ==========================================
// CPU bus master model: one-cycle writes and reads.
// Assumes the slave never stalls and answers a read a cycle later.
`timescale 1ns/10ps
`default_nettype none
module cpu_bus_model (
  input wire logic clk_i,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  initial
  begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // Idle lines carry inverted values so stale data cannot pass as valid.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
  begin
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= w;
    rd_o <= ~w;
    @(posedge clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  end
  endtask
endmodule
`default_nettype wire

// >>> test_data_eeprom_write_controller.sv
// ==========================================
// Testbench for the data EEPROM controller.
// Assumes cpu_bus_model drives the port and the checker is bound.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module test_data_eeprom_write_controller;
  logic clk_i, reset_n_i, wait_req_i, halt_req_i, protect_i, ext_access_i, unprotect_req_i;
  logic [7:0] addr_i, wdata_i, rdata_o, d;
  logic wr_i, rd_i, rd_d, rdata_oe_o, wait_ack_o, halted_o, busy_o, irq_o;
  logic [8:0] exp_q[$];
  logic [8:0] note;
  logic [7:0] mem_e [128];
  int err_count, compares, cyc, seed;
  cpu_bus_model u_cpu (.clk_i(clk_i), .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));
  eeprom_write_ctrl #(.PROG_CYCLES(40)) u_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .rdata_oe_o(rdata_oe_o), .wait_req_i(wait_req_i),
    .halt_req_i(halt_req_i), .protect_i(protect_i), .ext_access_i(ext_access_i),
    .unprotect_req_i(unprotect_req_i), .wait_ack_o(wait_ack_o), .halted_o(halted_o),
    .busy_o(busy_o), .irq_o(irq_o));
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    u_cpu.xfer(1'b1, a, v);
  endtask
  task automatic rdx(input logic [7:0] a, input logic [7:0] e, input logic oe);
  begin
    exp_q.push_back({oe, e});
    u_cpu.xfer(1'b0, a, 8'h00);
  end
  endtask
  // Row 3 entry 0 is skipped: a halted cycle leaves it undefined.
  task automatic chk_all;
    for (int i = 0; i < 128; i++)
      if (i != 96)
        rdx(8'h80 + 8'(i), mem_e[i], 1'b1);
  endtask
  task automatic wait_idle;
    int n;
  begin
    n = 0;
    repeat (3) @(posedge clk_i);
    while (busy_o !== 1'b0 && n < 300)
    begin
      @(posedge clk_i);
      n++;
    end
    `CHK("busy_o", 1'b0, busy_o)
  end
  endtask
  task automatic wrap_up;
  begin
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  always @(posedge clk_i)
  begin
    if (rd_d)
    begin
      note = exp_q.pop_front();
      `CHK("rdata_oe_o", note[8], rdata_oe_o)
      if (note[8])
        `CHK("rdata_o", note[7:0], rdata_o)
    end
    rd_d <= rd_i;
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      wrap_up();
    end
  end
  initial
  begin
    {reset_n_i, wait_req_i, halt_req_i, protect_i, ext_access_i, unprotect_req_i, rd_d} = 7'h00;
    seed = $urandom(32'hd8e4078b);
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rdx(8'h30, 8'h00, 1'b1);
    rdx(8'h32, 8'h00, 1'b1);
    $display("test reset values done");
    protect_i <= 1'b1;
    ext_access_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rdx(8'h80, 8'h00, 1'b0);
    unprotect_req_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    {protect_i, ext_access_i, unprotect_req_i} <= 3'b000;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < 128; i++)
      mem_e[i] = 8'hff;
    wr(8'h31, 8'h0f);
    rdx(8'h31, 8'h00, 1'b1);
    wr(8'h85, 8'h12);
    chk_all();
    $display("test erase and protection done");
    wr(8'h30, 8'h02);
    wr(8'h80, 8'h00);
    wr(8'h30, 8'h00);
    wr(8'h30, 8'h02);
    rdx(8'h30, 8'h02, 1'b1);
    rdx(8'h85, 8'h00, 1'b0);
    for (int c = 0; c < 32; c++)
    begin
      d = 8'($urandom);
      mem_e[32 + c] = d;
      wr(8'ha0 + 8'(c), d);
    end
    d = 8'($urandom);
    mem_e[35] = mem_e[35] & d;
    wr(8'ha3, d);
    wr(8'h30, 8'h03);
    rdx(8'h30, 8'h03, 1'b1);
    wr(8'h30, 8'h01);
    rdx(8'h30, 8'h03, 1'b1);
    wait_idle();
    rdx(8'h30, 8'h00, 1'b1);
    `CHK("irq_o", 1'b0, irq_o)
    wr(8'h32, 8'h01);
    repeat (2) @(posedge clk_i);
    `CHK("irq_o", 1'b1, irq_o)
    wr(8'h31, 8'h01);
    repeat (2) @(posedge clk_i);
    `CHK("irq_o", 1'b0, irq_o)
    $display("test row programming done");
    wr(8'h30, 8'h02);
    wr(8'hc0, 8'h5a);
    mem_e[64] = 8'h5a;
    wr(8'h30, 8'h03);
    wait_req_i <= 1'b1;
    @(posedge clk_i);
    `CHK("wait_ack_o", 1'b0, wait_ack_o)
    wait_idle();
    repeat (4) @(posedge clk_i);
    `CHK("wait_ack_o", 1'b1, wait_ack_o)
    wait_req_i <= 1'b0;
    $display("test wait done");
    wr(8'h30, 8'h02);
    wr(8'he0, 8'h00);
    wr(8'h30, 8'h03);
    halt_req_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    `CHK("halted_o", 1'b1, halted_o)
    `CHK("busy_o", 1'b0, busy_o)
    halt_req_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    rdx(8'h30, 8'h00, 1'b1);
    chk_all();
    $display("test halt and readback done");
    repeat (3) @(posedge clk_i);
    wrap_up();
  end
endmodule
`default_nettype wire
